/* sspp_host.sv */
// host model driving the programming pins
`timescale 1ns/1ps
module sspp_host (
	output logic sclk_o = 1'b0,
	output logic sdat_o = 1'b0,
	output logic stb_o  = 1'b0
);
	task automatic send(input logic [20:0] w);
		#7;
		for (int i = 20; i >= 0; i--) begin
			sdat_o = w[i];
			#200 sclk_o = 1'b1;
			#200 sclk_o = 1'b0;
		end
		sdat_o = ~w[0];
		#200 stb_o = 1'b1;
		#200 stb_o = 1'b0;
	endtask
endmodule

/* sspp_pkg.sv */
// package: constants and types of the serial programming port
package sspp_pkg;
	localparam int unsigned SHIFT_W       = 21;
	localparam int unsigned CTRL_W        = 2;
	localparam int unsigned PAYLOAD_W     = SHIFT_W - CTRL_W;
	localparam int unsigned NUM_LATCH     = 3;
	localparam logic [1:0]  CTRL_REF      = 2'h0;
	localparam logic [1:0]  CTRL_NDIV     = 2'h1;
	localparam logic [1:0]  CTRL_FUNC     = 2'h2;
	localparam logic [1:0]  CTRL_INIT     = 2'h3;
	localparam int unsigned PD_BIT_POS    = 2;
	localparam int unsigned MUXSEL_LSB    = 4;
	localparam logic [PAYLOAD_W-1:0] LATCH_RST = 19'h00000;
	localparam logic [1:0]  MUXSEL_LOCK   = 2'h0;
	localparam logic [1:0]  MUXSEL_RFDIV  = 2'h1;
	localparam logic [1:0]  MUXSEL_REFDIV = 2'h2;
endpackage

/* sspp_port.sv */
// module: serial programming port with chip-enable power control
//
// Notes on behaviour
// - each rising serial clock edge shifts the data pin into a 21-bit shift register, data valid before the edge.
// - the last two bits shifted in are control bits that pick the destination and are not payload.
// - a rising load strobe copies the shift register into one of three latches chosen by the control bits.
// - while chip enable is low the device is powered down and the charge pump output is released.
// - raising chip enable powers up only if the programmed power-down bit allows it.
// - the multiplexed output carries the RF divider output, the reference divider output or lock detect.
`timescale 1ns/1ps
module sspp_port
	import sspp_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 nrst_i,
	input  wire logic                 ser_clk_i,
	input  wire logic                 ser_data_i,
	input  wire logic                 load_strobe_i,
	input  wire logic                 chip_en_i,
	input  wire logic                 rf_div_i,
	input  wire logic                 ref_div_i,
	input  wire logic                 lock_det_i,
	input  wire logic                 pump_up_i,
	input  wire logic                 pump_dn_i,
	output logic                      pump_out_o,
	output logic                      pump_out_oe_o,
	output logic                      powered_o,
	output logic                      mux_test_lock_out_o,
	output logic [PAYLOAD_W-1:0]      ref_latch_o,
	output logic [PAYLOAD_W-1:0]      ndiv_latch_o,
	output logic [PAYLOAD_W-1:0]      func_latch_o,
	output logic                      load_pulse_o
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [6:0] pins_s;
	logic       sclk_s, sdat_s, stb_s, ce_s, rfd_s, refd_s, lock_s;

	sspp_sync #(
		.W(7)
	) u_sync (
		.clk_i (clk_i),
		.nrst_i(nrst_i),
		.d_i   ({ser_clk_i, ser_data_i, load_strobe_i, chip_en_i, rf_div_i, ref_div_i, lock_det_i}),
		.q_o   (pins_s)
	);

	assign {sclk_s, sdat_s, stb_s, ce_s, rfd_s, refd_s, lock_s} = pins_s;

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic                 sclk_d;
		logic                 stb_d;
		logic [SHIFT_W-1:0]   shift;
		logic [PAYLOAD_W-1:0] latch0;
		logic [PAYLOAD_W-1:0] latch1;
		logic [PAYLOAD_W-1:0] latch2;
		logic                 load_pulse;
		logic                 powered;
		logic                 mux_out;
	} sspp_state_t;

	sspp_state_t state_reg, state_next;

	function automatic logic [1:0] sspp_muxsel(input logic [PAYLOAD_W-1:0] f);
		return f[MUXSEL_LSB +: 2];
	endfunction

	always_comb begin
		state_next            = state_reg;
		state_next.sclk_d     = sclk_s;
		state_next.stb_d      = stb_s;
		state_next.load_pulse = 1'b0;
		// shift on rising serial clock, msb first
		if (sclk_s && !state_reg.sclk_d) begin
			state_next.shift = {state_reg.shift[SHIFT_W-2:0], sdat_s};
		end
		// latch only on rising load strobe
		if (stb_s && !state_reg.stb_d) begin
			state_next.load_pulse = 1'b1;
			unique case (state_reg.shift[CTRL_W-1:0])
				CTRL_REF:  state_next.latch0 = state_reg.shift[SHIFT_W-1:CTRL_W];
				CTRL_NDIV: state_next.latch1 = state_reg.shift[SHIFT_W-1:CTRL_W];
				CTRL_FUNC: state_next.latch2 = state_reg.shift[SHIFT_W-1:CTRL_W];
				CTRL_INIT: begin
					state_next.latch2 = state_reg.shift[SHIFT_W-1:CTRL_W];
				end
			endcase
		end
		// power: chip enable and power-down bit
		state_next.powered = ce_s && !state_reg.latch2[PD_BIT_POS];
		unique case (sspp_muxsel(state_reg.latch2))
			MUXSEL_LOCK:   state_next.mux_out = lock_s;
			MUXSEL_RFDIV:  state_next.mux_out = rfd_s;
			MUXSEL_REFDIV: state_next.mux_out = refd_s;
			default:       state_next.mux_out = lock_s;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			state_reg <= '{sclk_d: 1'b0, stb_d: 1'b0, shift: '0, latch0: LATCH_RST, latch1: LATCH_RST,
				latch2: LATCH_RST, load_pulse: 1'b0, powered: 1'b0, mux_out: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign pump_out_oe_o       = state_reg.powered && (pump_up_i ^ pump_dn_i);
	assign pump_out_o          = pump_up_i;
	assign powered_o           = state_reg.powered;
	assign mux_test_lock_out_o = state_reg.mux_out;
	assign ref_latch_o         = state_reg.latch0;
	assign ndiv_latch_o        = state_reg.latch1;
	assign func_latch_o        = state_reg.latch2;
	assign load_pulse_o        = state_reg.load_pulse;
endmodule

/* sspp_port_assertions.sv */
// checker: assertions on the port pins
`timescale 1ns/1ps
module sspp_port_chk
	import sspp_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        nrst_i,
	input wire logic        load_strobe_i,
	input wire logic        chip_en_i,
	input wire logic        lock_det_i,
	input wire logic        pump_out_oe_o,
	input wire logic        powered_o,
	input wire logic        mux_test_lock_out_o,
	input wire logic        load_pulse_o,
	input wire logic [18:0] ref_latch_o,
	input wire logic [18:0] ndiv_latch_o,
	input wire logic [18:0] func_latch_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	oe_down_a: assert property (pump_out_oe_o |-> powered_o) else $error("pump on while down");
	ce_low_a: assert property (!chip_en_i [*5] |-> !powered_o) else $error("up, enable low");
	pwr_bit_a: assert property (chip_en_i [*5] ##0 $stable(func_latch_o) [*2]
		|-> powered_o == !func_latch_o[PD_BIT_POS]) else $error("power state");
	hold_a: assert property (!load_pulse_o |-> $stable({ref_latch_o, ndiv_latch_o, func_latch_o}))
		else $error("latch moved");
	one_latch_a: assert property (load_pulse_o |-> $onehot0({$changed(ref_latch_o),
		$changed(ndiv_latch_o), $changed(func_latch_o)})) else $error("two latches");
	strobe_load_a: assert property ($rose(load_strobe_i) |-> ##[1:4] load_pulse_o) else $error("no load");
	mux_lock_a: assert property ((func_latch_o[MUXSEL_LSB+:2] == MUXSEL_LOCK && lock_det_i) [*5]
		|-> mux_test_lock_out_o) else $error("mux wrong");
	cover property (load_pulse_o && $changed(func_latch_o));
	cover property ($fell(powered_o));
	cover property ($rose(powered_o));
endmodule
bind sspp_port sspp_port_chk u_chk (.clk_i, .nrst_i, .load_strobe_i, .chip_en_i, .lock_det_i, .pump_out_oe_o,
	.powered_o, .mux_test_lock_out_o, .load_pulse_o, .ref_latch_o, .ndiv_latch_o, .func_latch_o);

/* sspp_sync.sv */
// module: two flip-flop synchroniser for a group of pins
`timescale 1ns/1ps
module sspp_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			meta_reg <= '0;
			q_reg    <= '0;
		end else begin
			meta_reg <= d_i;
			q_reg    <= meta_reg;
		end
	end

	assign q_o = q_reg;
endmodule

/* testbench.sv */
// testbench of the serial programming port
`timescale 1ns/1ps
module testbench;
	import sspp_pkg::*;
	logic        clk_i = 1'b0, nrst_i = 1'b0, chip_en_i = 1'b0, sc, sd, st, oe, pw;
	logic [18:0] rl, nl, fl;
	logic        rfd = 1'b0, refd = 1'b0, lock = 1'b1, pup = 1'b1, pdn = 1'b0, mo, po, lp;
	int          fail_count = 0, n_checks = 0, n_loads = 0;
	logic [40:0] rows [4] = '{{21'h1ffffc, 19'h7ffff, 1'b1}, {21'h0aaaa9, 19'h2aaaa, 1'b1},
		{21'h000052, 19'h00014, 1'b0}, {21'h000003, 19'h00000, 1'b1}};
	sspp_host host (.sclk_o(sc), .sdat_o(sd), .stb_o(st));
	sspp_port dut (.clk_i, .nrst_i, .ser_clk_i(sc), .ser_data_i(sd), .load_strobe_i(st), .chip_en_i,
		.rf_div_i(rfd), .ref_div_i(refd), .lock_det_i(lock), .pump_up_i(pup), .pump_dn_i(pdn),
		.pump_out_o(po), .pump_out_oe_o(oe), .powered_o(pw), .mux_test_lock_out_o(mo), .ref_latch_o(rl),
		.ndiv_latch_o(nl), .func_latch_o(fl), .load_pulse_o(lp));
	always @(posedge clk_i) begin
		if (lp === 1'b1) begin
			n_loads <= n_loads + 1;
		end
	end
	task automatic chk(input logic [18:0] g, e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	initial begin
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'b1;
		chip_en_i <= 1'b1;
		foreach (rows[i]) begin
			host.send(rows[i][40:20]);
			repeat (2) @(negedge clk_i);
			chk(rows[i][21] ? fl : rows[i][20] ? nl : rl, rows[i][19:1]);
			chk({pw, oe, 17'h0}, {rows[i][0], rows[i][0], 17'h0});
			chk(19'(n_loads), 19'(i + 1));
			$display("row %0d done", i);
		end
		@(posedge clk_i);
		pdn <= 1'b1;
		@(negedge clk_i);
		chk({oe, 18'h0}, 19'h0);
		@(posedge clk_i);
		pup <= 1'b0;
		@(negedge clk_i);
		chk({oe, po, 17'h0}, 19'h40000);
		@(posedge clk_i);
		pup <= 1'b1;
		pdn <= 1'b0;
		$display("pump done");
		@(posedge clk_i);
		lock <= 1'b0;
		repeat (4) @(negedge clk_i);
		chk({mo, 18'h0}, 19'h0);
		@(posedge clk_i);
		lock <= 1'b1;
		repeat (4) @(negedge clk_i);
		chk({mo, 18'h0}, 19'h40000);
		host.send(21'h000042);
		repeat (4) @(negedge clk_i);
		chk({mo, 18'h0}, 19'h0);
		@(posedge clk_i);
		rfd <= 1'b1;
		repeat (4) @(negedge clk_i);
		chk({mo, 18'h0}, 19'h40000);
		@(posedge clk_i);
		rfd <= 1'b0;
		host.send(21'h000082);
		repeat (4) @(negedge clk_i);
		chk({mo, 18'h0}, 19'h0);
		@(posedge clk_i);
		refd <= 1'b1;
		repeat (4) @(negedge clk_i);
		chk({mo, 18'h0}, 19'h40000);
		@(posedge clk_i);
		refd <= 1'b0;
		host.send(21'h000003);
		repeat (2) @(negedge clk_i);
		chk(fl, 19'h0);
		$display("mux done");
		@(posedge clk_i);
		chip_en_i <= 1'b0;
		repeat (5) @(negedge clk_i);
		chk({pw, oe, 17'h0}, 19'h0);
		$display("enable low done");
		@(posedge clk_i);
		nrst_i <= 1'b0;
		chip_en_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (6) @(negedge clk_i);
		chk(rl | nl | fl, LATCH_RST);
		chk({pw, 18'h0}, 19'h40000);
		$display("reset done");
		conclude();
	end
endmodule
